// *** logic/lcc_cluster.sv ***
// Functional notes
// RULE1: Each cell is normal or arithmetic mode
// RULE2: Cell takes eight inputs incl. carries, chain
// RULE3: Register controls come from cluster-wide signals
// RULE4: Add/subtract select acts in arithmetic only
// RULE5: Fourth lookup input is data or carry
// RULE6: Lookup chain feeds next cell directly
// RULE7: Asynchronous load value is fourth data input
// RULE8: Packing lets register and lookup differ
// RULE9: Carry into lookup only at chain end
// RULE10: Arithmetic precomputes sums and carries per rail
// RULE11: Cluster carry picks rail, rail picks sum
// RULE12: Each rail input selects its own carry-out
// RULE13: Counter enable, direction from local data
// RULE14: Synchronous clear/load act on next tick
// RULE15: Add/subtract drives first chain cell carry
// RULE16: Chains start anywhere, both rails propagate
// RULE17: Cluster carry generated at cells five, ten
// RULE18: Final carry routed out; sum registered/bypassed
// RULE19: Chains continue across vertically linked clusters; carries are output here, but chain inputs come from control bits or constants, not ports
// RULE20: Preset is load high; clear wins
// RULE21: Two clears and one preset per cluster
// RULE22: Optional device clear overrides every control
// RULE23: Subtract inverts operand two, carry one
// RULE24: Two clocks each gated by own enable
// RULE25: Rail sum xor, rail carry majority
//
// The AXI4-Lite slave port and the register offsets were decided locally.
module lcc_cluster
   import lcc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_device_wide_clear_n,
   output logic [NCELL-1:0] o_reg_out,
   output logic [NCELL-1:0] o_comb_out,
   output logic o_cluster_carry_out,
   output logic o_zero_rail_carry_out,
   output logic o_one_rail_carry_out
);
   lcc_st_t r; // Registered state
   lcc_st_t n; // Next state
   logic [NCELL-1:0] zr_in, or_in, zr_out, or_out; // Carry rails
   logic [NCELL-1:0] comb, q, lch, rch, ccin; // Cell links
   logic mid; // Carry generated after the fifth cell
   logic fin; // Carry generated after the tenth cell
   logic dev_clr; // Device clear, after option gating
   logic [31:0] status; // Status word

   // Decode a byte address into a register
   function automatic lcc_reg_t lcc_decode(input logic [7:0] addr);
      lcc_reg_t res;
      res = LCC_R_NONE;
      if (addr == OFS_CTRL)
         res = LCC_R_CTRL;
      else if (addr == OFS_TICK)
         res = LCC_R_TICK;
      else if (addr == OFS_STAT)
         res = LCC_R_STAT;
      else if ((addr >= OFS_CELL) && (addr < OFS_CELL + 8'(4 * NCELL)) && (addr[1:0] == 2'h0))
         res = LCC_R_CELL;
      return res;
   endfunction : lcc_decode

   // Cell index of a cell word address
   function automatic logic [3:0] lcc_idx(input logic [7:0] addr);
      logic [7:0] off;
      off = addr - OFS_CELL;
      return off[5:2];
   endfunction : lcc_idx

   // Merge write data under byte strobes
   function automatic logic [31:0] lcc_merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[8*i +: 8] = nw[8*i +: 8];
      end
      return res;
   endfunction : lcc_merge

   // Device clear acts only when the option bit allows it
   assign dev_clr = r.ctrl[CT_DEVOPT] & ~r.clr_s2; // [RULE22]

   // Carry generation points of the cluster
   assign mid = r.ctrl[CT_CCIN] ? or_out[MIDCELL] : zr_out[MIDCELL]; // [RULE17]
   assign fin = mid ? or_out[NCELL-1] : zr_out[NCELL-1]; // [RULE17] [RULE19]

   // Status word shows cell and carry state
   assign status = {8'h00, r.orr, r.zr, mid, r.ccout, r.comb, q};

   // Cell array with its chains
   genvar g;
   generate
      for (g = 0; g < NCELL; g++)
      begin : g_cell
         if (g == 0)
         begin : g_first
            // First cell takes the register chain from the control word
            assign lch[g] = 1'b0;
            assign rch[g] = r.ctrl[CT_RCHAIN];
         end
         else
         begin : g_next
            // Lookup and register chains from the cell below
            assign lch[g] = comb[g-1]; // [RULE6]
            assign rch[g] = q[g-1];
         end
         if (g % HALF == 0)
         begin : g_head
            // Group head starts fresh rails, or the subtract carry
            assign zr_in[g] = r.cfg[g][CF_START] ? r.ctrl[CT_ADDNSUB] : 1'b0; // [RULE15]
            assign or_in[g] = r.cfg[g][CF_START] ? r.ctrl[CT_ADDNSUB] : 1'b1; // [RULE15]
         end
         else
         begin : g_body
            // Rails run forward unless a new chain starts here
            assign zr_in[g] = r.cfg[g][CF_START] ? r.ctrl[CT_ADDNSUB] : zr_out[g-1]; // [RULE16]
            assign or_in[g] = r.cfg[g][CF_START] ? r.ctrl[CT_ADDNSUB] : or_out[g-1]; // [RULE16]
         end
         // Lower group uses the incoming cluster carry, upper group the mid carry
         assign ccin[g] = (g <= MIDCELL) ? r.ctrl[CT_CCIN] : mid; // [RULE17]
         lcc_cell u_cell (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_cfg(r.cfg[g]),
            .i_lut_chain_in(lch[g]),
            .i_zero_rail_carry_in(zr_in[g]),
            .i_one_rail_carry_in(or_in[g]),
            .i_cluster_carry_in(ccin[g]),
            .i_reg_chain_in(rch[g]),
            .i_addnsub(r.ctrl[CT_ADDNSUB]),
            .i_tick_a(r.tick_a),
            .i_tick_b(r.tick_b),
            .i_aclr_a(r.ctrl[CT_ACLR_A]),
            .i_aclr_b(r.ctrl[CT_ACLR_B]),
            .i_aload(r.ctrl[CT_ALOAD]),
            .i_sclr(r.ctrl[CT_SCLR]),
            .i_sload(r.ctrl[CT_SLOAD]),
            .i_dev_clr(dev_clr),
            .o_comb(comb[g]),
            .o_q(q[g]),
            .o_zero_rail_carry_out(zr_out[g]),
            .o_one_rail_carry_out(or_out[g])
         ); // [RULE2]
      end
   endgenerate

   // Bus slave, clock ticks, pin synchroniser and output capture
   always_comb
   begin
      n = r;
      // Two-stage synchroniser on the device clear pin
      n.clr_s1 = i_device_wide_clear_n;
      n.clr_s2 = r.clr_s1;
      // Free-running ticks, each gated by its own enable
      n.tick_a = r.ctrl[CT_FREE] & r.ctrl[CT_CKEN_A]; // [RULE24]
      n.tick_b = r.ctrl[CT_FREE] & r.ctrl[CT_CKEN_B]; // [RULE24]
      // Write address and data are taken independently
      if (r.awready && i_awvalid)
      begin
         n.aw_got = 1'b1;
         n.awaddr = i_awaddr;
      end
      if (r.wready && i_wvalid)
      begin
         n.w_got = 1'b1;
         n.wdata = i_wdata;
         n.wstrb = i_wstrb;
      end
      // Response consumed
      if (r.bvalid && i_bready)
         n.bvalid = 1'b0;
      // Perform the write once both halves are in
      if (n.aw_got && n.w_got && !n.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OK;
         case (lcc_decode(n.awaddr))
            LCC_R_CTRL: n.ctrl = lcc_merge(r.ctrl, n.wdata, n.wstrb); // [RULE3]
            LCC_R_TICK:
            begin
               // Single tick per written bit, gated by its enable
               n.tick_a = n.tick_a | (n.wdata[TK_A] & n.wstrb[0] & r.ctrl[CT_CKEN_A]);
               n.tick_b = n.tick_b | (n.wdata[TK_B] & n.wstrb[0] & r.ctrl[CT_CKEN_B]);
            end
            LCC_R_CELL: n.cfg[lcc_idx(n.awaddr)] =
               lcc_merge(r.cfg[lcc_idx(n.awaddr)], n.wdata, n.wstrb); // [RULE1]
            LCC_R_STAT: n.bresp = RESP_OK; // Read-only, write ignored
            default: n.bresp = RESP_ERR; // Unmapped address
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      // Read data consumed
      if (r.rvalid && i_rready)
         n.rvalid = 1'b0;
      // Read request answered at the edge that takes it
      if (r.arready && i_arvalid)
      begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OK;
         case (lcc_decode(i_araddr))
            LCC_R_CTRL: n.rdata = r.ctrl;
            LCC_R_TICK: n.rdata = 32'h0000_0000; // Pulses read as zero
            LCC_R_STAT: n.rdata = status;
            LCC_R_CELL: n.rdata = r.cfg[lcc_idx(i_araddr)];
            default:
            begin
               n.rdata = 32'h0000_0000;
               n.rresp = RESP_ERR; // Unmapped address
            end
         endcase
      end
      n.arready = !n.rvalid;
      // Registered copies of combinational and carry outputs
      n.comb = comb; // [RULE18]
      n.ccout = fin; // [RULE18] [RULE19]
      n.zr = zr_out[NCELL-1]; // [RULE19]
      n.orr = or_out[NCELL-1]; // [RULE19]
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         r <= '0;
         r.ctrl <= CTRL_RST;
         r.cfg <= {NCELL{CELL_RST}};
      end
      else
         r <= n;
   end

   // Outputs
   assign o_awready = r.awready;
   assign o_wready = r.wready;
   assign o_bresp = r.bresp;
   assign o_bvalid = r.bvalid;
   assign o_arready = r.arready;
   assign o_rdata = r.rdata;
   assign o_rresp = r.rresp;
   assign o_rvalid = r.rvalid;
   assign o_reg_out = q;
   assign o_comb_out = r.comb;
   assign o_cluster_carry_out = r.ccout;
   assign o_zero_rail_carry_out = r.zr;
   assign o_one_rail_carry_out = r.orr;

   // Helper vectors for checking
   logic [NCELL-1:0] av, bv, ar_v, st_v, lc_v, cn_v, ld_v, cla_v, ona_v;
   logic [10:0] exp_sum; // Expected ten-bit sum with carry
   logic all_add; // Whole cluster is one plain adder
   generate
      for (g = 0; g < NCELL; g++)
      begin : g_chk
         assign av[g] = r.cfg[g][CF_DATA];
         assign bv[g] = r.cfg[g][CF_DATA + 1];
         assign ar_v[g] = r.cfg[g][CF_ARITH];
         assign st_v[g] = r.cfg[g][CF_START];
         assign lc_v[g] = r.cfg[g][CF_LCHAIN];
         assign cn_v[g] = r.cfg[g][CF_CNT];
         assign ld_v[g] = r.cfg[g][CF_PRESET] | r.cfg[g][CF_DATA + 3];
         assign cla_v[g] = (r.cfg[g][CF_ACLR +: 2] == ACLR_A);
         assign ona_v[g] = ~r.cfg[g][CF_CLKSEL];
      end
   endgenerate
   assign all_add = (&ar_v) && (st_v == 10'h001) && (lc_v == '0) && (cn_v == '0);
   assign exp_sum = 11'({1'b0, av} + {1'b0, bv ^ {NCELL{r.ctrl[CT_ADDNSUB]}}}
      + {10'h000, r.ctrl[CT_ADDNSUB]});

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // No asynchronous control is active
   sequence s_async_quiet;
      !dev_clr && !r.ctrl[CT_ACLR_A] && !r.ctrl[CT_ACLR_B] && !r.ctrl[CT_ALOAD];
   endsequence

   // Cluster configured as one ten-bit adder
   sequence s_add_cfg;
      all_add;
   endsequence

   property p_adder;
      s_add_cfg |=> (o_comb_out == $past(exp_sum[9:0]))
         && (o_cluster_carry_out == $past(exp_sum[10]));
   endproperty
   a_adder: assert property (p_adder) else $error("Adder sum or carry wrong"); // [RULE11]

   property p_rails;
      (zr_out & ~or_out) == '0;
   endproperty
   a_rails: assert property (p_rails) else $error("Zero rail above one rail"); // [RULE12]

   property p_dev_clear;
      dev_clr |=> (o_reg_out == '0);
   endproperty
   a_dev_clear: assert property (p_dev_clear) else $error("Device clear missed"); // [RULE22]

   property p_clr_wins;
      (r.ctrl[CT_ACLR_A] && r.ctrl[CT_ALOAD]) |=> ((o_reg_out & $past(cla_v)) == '0);
   endproperty
   a_clr_wins: assert property (p_clr_wins) else $error("Clear lost to load"); // [RULE20]

   // Asynchronous load asserted while every clear is quiet
   sequence s_load_only;
      r.ctrl[CT_ALOAD] && !dev_clr && !r.ctrl[CT_ACLR_A] && !r.ctrl[CT_ACLR_B];
   endsequence

   property p_aload;
      s_load_only |=> (o_reg_out == $past(ld_v));
   endproperty
   a_aload: assert property (p_aload) else $error("Load value wrong"); // [RULE7]

   property p_tick_gate;
      !r.ctrl[CT_CKEN_A] |=> !r.tick_a;
   endproperty
   a_tick_gate: assert property (p_tick_gate) else $error("Clock ran while off"); // [RULE24]

   property p_hold;
      (s_async_quiet and (!r.tick_a && !r.tick_b)) |=> $stable(o_reg_out);
   endproperty
   a_hold: assert property (p_hold) else $error("Register moved untimed"); // [RULE3]

   property p_sclr;
      (s_async_quiet and (r.tick_a && r.ctrl[CT_SCLR])) |=> ((o_reg_out & $past(ona_v)) == '0);
   endproperty
   a_sclr: assert property (p_sclr) else $error("Sync clear missed"); // [RULE14]
endmodule : lcc_cluster

// *** logic/lcc_pkg.sv ***
package lcc_pkg;
   // Cluster geometry
   localparam int NCELL = 10;
   localparam int HALF = 5;
   localparam int MIDCELL = 4;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TICK = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CELL = 8'h40;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CELL_RST = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // Control register fields
   localparam int CT_CCIN = 0;
   localparam int CT_ADDNSUB = 1;
   localparam int CT_CKEN_A = 2;
   localparam int CT_CKEN_B = 3;
   localparam int CT_FREE = 4;
   localparam int CT_ACLR_A = 5;
   localparam int CT_ACLR_B = 6;
   localparam int CT_ALOAD = 7;
   localparam int CT_SCLR = 8;
   localparam int CT_SLOAD = 9;
   localparam int CT_DEVOPT = 10;
   localparam int CT_RCHAIN = 11;
   // Tick register fields
   localparam int TK_A = 0;
   localparam int TK_B = 1;
   // Cell word fields
   localparam int CF_MASK = 0;
   localparam int CF_ARITH = 16;
   localparam int CF_LUT3C = 17;
   localparam int CF_START = 18;
   localparam int CF_CEND = 19;
   localparam int CF_LCHAIN = 20;
   localparam int CF_RSRC = 21;
   localparam int CF_CLKSEL = 23;
   localparam int CF_ACLR = 24;
   localparam int CF_PRESET = 26;
   localparam int CF_CNT = 27;
   localparam int CF_DATA = 28;
   // Clear selection and register source codes
   localparam logic [1:0] ACLR_A = 2'h1;
   localparam logic [1:0] ACLR_B = 2'h2;
   localparam logic [1:0] RS_CHAIN = 2'h1;
   localparam logic [1:0] RS_DIRECT = 2'h2;
   // Register decode result
   typedef enum logic [2:0] {LCC_R_CTRL, LCC_R_TICK, LCC_R_STAT, LCC_R_CELL, LCC_R_NONE} lcc_reg_t;
   // Cell state
   typedef struct packed {
      logic q;
   } lcc_cell_st_t;
   // Cluster state
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [NCELL-1:0][31:0] cfg;
      logic tick_a;
      logic tick_b;
      logic clr_s1;
      logic clr_s2;
      logic [NCELL-1:0] comb;
      logic ccout;
      logic zr;
      logic orr;
   } lcc_st_t;
endpackage : lcc_pkg

// *** logic/lcc_cell.sv ***
module lcc_cell
   import lcc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [31:0] i_cfg,
   input wire logic i_lut_chain_in,
   input wire logic i_zero_rail_carry_in,
   input wire logic i_one_rail_carry_in,
   input wire logic i_cluster_carry_in,
   input wire logic i_reg_chain_in,
   input wire logic i_addnsub,
   input wire logic i_tick_a,
   input wire logic i_tick_b,
   input wire logic i_aclr_a,
   input wire logic i_aclr_b,
   input wire logic i_aload,
   input wire logic i_sclr,
   input wire logic i_sload,
   input wire logic i_dev_clr,
   output logic o_comb,
   output logic o_q,
   output logic o_zero_rail_carry_out,
   output logic o_one_rail_carry_out
);
   lcc_cell_st_t r; // Registered state
   lcc_cell_st_t n; // Next state
   logic [3:0] d; // Local data inputs
   logic [15:0] lmask; // Lookup truth table
   logic arith, cnt, a, b, sub, sel, in3, lut, s0, s1, comb, rdat, tick, aclr;

   // Lookup, dual-rail arithmetic and register priority
   always_comb
   begin
      d = i_cfg[CF_DATA +: 4];
      lmask = i_cfg[CF_MASK +: 16];
      arith = i_cfg[CF_ARITH]; // [RULE1]
      cnt = arith & i_cfg[CF_CNT];
      sel = i_cluster_carry_in ? i_one_rail_carry_in : i_zero_rail_carry_in; // [RULE11]
      a = cnt ? r.q : (i_cfg[CF_LCHAIN] ? i_lut_chain_in : d[0]); // [RULE6]
      in3 = (i_cfg[CF_LUT3C] & i_cfg[CF_CEND]) ? sel : d[3]; // [RULE5] [RULE9]
      lut = lmask[{in3, d[2], d[1], a}];
      sub = arith & (i_addnsub ^ (cnt & ~d[3])); // [RULE4] [RULE13]
      b = d[1] ^ sub; // [RULE23]
      s0 = a ^ b; // [RULE10] [RULE25]
      s1 = ~s0;
      comb = arith ? (sel ? s1 : s0) : lut; // [RULE11]
      if (arith)
      begin
         // Each rail selects its own precomputed carry
         o_zero_rail_carry_out = i_zero_rail_carry_in ? (a | b) : (a & b); // [RULE12]
         o_one_rail_carry_out = i_one_rail_carry_in ? (a | b) : (a & b); // [RULE12]
      end
      else
      begin
         // Normal mode passes the rails through
         o_zero_rail_carry_out = i_zero_rail_carry_in;
         o_one_rail_carry_out = i_one_rail_carry_in;
      end
      case (i_cfg[CF_RSRC +: 2])
         RS_CHAIN: rdat = i_reg_chain_in;
         RS_DIRECT: rdat = d[2]; // [RULE8]
         default: rdat = comb; // [RULE18]
      endcase
      tick = i_cfg[CF_CLKSEL] ? i_tick_b : i_tick_a; // [RULE24]
      aclr = ((i_cfg[CF_ACLR +: 2] == ACLR_A) & i_aclr_a)
         | ((i_cfg[CF_ACLR +: 2] == ACLR_B) & i_aclr_b); // [RULE21]
      n = r;
      if (i_dev_clr)
         n.q = 1'b0; // [RULE22]
      else if (aclr)
         n.q = 1'b0; // [RULE20]
      else if (i_aload)
         n.q = i_cfg[CF_PRESET] | d[3]; // [RULE7] [RULE20]
      else if (tick)
      begin
         if (i_sclr)
            n.q = 1'b0; // [RULE14]
         else if (i_sload)
            n.q = d[3]; // [RULE14]
         else if (!cnt || d[2])
            n.q = rdat; // [RULE3] [RULE13]
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         r <= '0;
      else
         r <= n;
   end

   assign o_comb = comb;
   assign o_q = r.q;
endmodule : lcc_cell

// *** verification/lcc_ctl_model.sv ***
// Bench-side control source that owns the device clear pin
module lcc_ctl_model
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_clear_req,
   output logic o_device_wide_clear_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin is driven low one edge after a request, as external logic would do
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_device_wide_clear_n <= 1'b1; // Idle high while reset
      end
      else
      begin
         o_device_wide_clear_n <= !i_clear_req;
      end
   end
endmodule : lcc_ctl_model

// *** verification/tb_top.sv ***
// Self-checking bench for the logic cluster
module tb_top
   import lcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'b0; // Bench clock
   logic i_rst_n = 1'b0; // Reset, active low
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, clear_req = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, clr_n, cc_out, zr_out, or_out;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [NCELL-1:0] reg_out, comb_out;
   int miscompares = 0; // Mismatch count
   int check_count = 0; // Comparison count
   // 100 MHz clock
   always #5 i_clk = ~i_clk;
   lcc_cluster i_lcc_cluster (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_device_wide_clear_n(clr_n), .o_reg_out(reg_out), .o_comb_out(comb_out),
      .o_cluster_carry_out(cc_out), .o_zero_rail_carry_out(zr_out),
      .o_one_rail_carry_out(or_out));
   lcc_ctl_model i_lcc_ctl_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_clear_req(clear_req), .o_device_wide_clear_n(clr_n));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask : wait_clk
   // Bus write: both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      @(posedge i_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge i_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            bready <= 1'b0;
            resp = bresp;
            break;
         end
      end
   endtask : wr
   // Bus read: address held until taken, rready held until data seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge i_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rready <= 1'b0;
            d = rdata;
            resp = rresp;
            break;
         end
      end
   endtask : rd
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(RESP_OK));
   endtask : wr_ok
   // Reset values, write-only tick, unmapped address
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd(OFS_CTRL, d, r);
      chk(d, CTRL_RST);
      rd(OFS_CELL, d, r);
      chk(d, CELL_RST);
      rd(OFS_TICK, d, r);
      chk(d, 32'h0000_0000);
      rd(8'h80, d, r);
      chk({d[29:0], r}, {30'h0000_0000, RESP_ERR});
   endtask : t_regs
   // Ripple add and subtract over three arithmetic cells, 3 +/- 1
   task automatic t_arith();
      wr_ok(OFS_CELL, 32'h3005_0000);
      wr_ok(8'h44, 32'h1001_0000);
      wr_ok(8'h48, 32'h0001_0000);
      wr_ok(OFS_CTRL, 32'h0000_0000);
      wait_clk(4);
      chk(32'(comb_out[2:0]), 32'h0000_0004);
      wr_ok(OFS_CTRL, 32'h0000_0002);
      wait_clk(4);
      chk(32'(comb_out[2:0]), 32'h0000_0002);
      wr_ok(OFS_CTRL, 32'h0000_0001);
      wait_clk(4);
      chk(32'(comb_out[2:0]), 32'h0000_0004);
   endtask : t_arith
   // Ten-cell chain across both rail groups, add then subtract
   task automatic t_wide();
      logic [9:0] a, b, bx;
      logic [10:0] s;
      logic [5:0] h0, h1;
      logic [31:0] d;
      logic [1:0] r;
      a = 10'h3FF;
      b = 10'h001;
      for (int i = 0; i < NCELL; i++)
      begin
         wr_ok(OFS_CELL + 8'(4 * i), {2'h0, b[i], a[i], 9'h000, 1'(i == 0), 2'h1, 16'h0000});
      end
      for (int m = 0; m < 2; m++)
      begin
         bx = b ^ {NCELL{m[0]}};
         s = {1'b0, a} + {1'b0, bx} + 11'(m);
         h0 = {1'b0, a[9:5]} + {1'b0, bx[9:5]};
         h1 = h0 + 6'h01;
         wr_ok(OFS_CTRL, 32'(m << CT_ADDNSUB));
         wait_clk(4);
         chk(32'(comb_out), 32'(s[9:0]));
         chk(32'(cc_out), 32'(s[10]));
         chk(32'({or_out, zr_out}), 32'({h1[5], h0[5]}));
         rd(OFS_STAT, d, r);
         chk(32'(d[20:10]), 32'(s));
      end
   endtask : t_wide
   // Normal-mode lookup and register control priority on cell 3
   task automatic t_reg();
      wr_ok(8'h4C, 32'hF500_8000);
      wr_ok(OFS_CTRL, 32'h0000_0004);
      wait_clk(3);
      chk(32'(comb_out[3]), 32'h0000_0001);
      wr_ok(OFS_TICK, 32'h0000_0001);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0001);
      wr_ok(OFS_CTRL, 32'h0000_00A4);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0000);
      wr_ok(OFS_CTRL, 32'h0000_0084);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0001);
      wr_ok(8'h4C, 32'hF500_0000);
      wr_ok(OFS_CTRL, 32'h0000_0000);
      wr_ok(OFS_TICK, 32'h0000_0001);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0001);
      wr_ok(OFS_CTRL, 32'h0000_0004);
      wr_ok(OFS_TICK, 32'h0000_0001);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0000);
      wr_ok(8'h4C, 32'hF540_0000);
      wr_ok(OFS_TICK, 32'h0000_0001);
      wait_clk(3);
      chk(32'({comb_out[3], reg_out[3]}), 32'h0000_0001);
   endtask : t_reg
   // Device clear beats the asynchronous load
   task automatic t_devclr();
      wr_ok(OFS_CTRL, 32'h0000_0084);
      wait_clk(3);
      chk(32'(reg_out[3]), 32'h0000_0001);
      wr_ok(OFS_CTRL, 32'h0000_0484);
      clear_req <= 1'b1;
      wait_clk(6);
      chk(32'(reg_out[3]), 32'h0000_0000);
      clear_req <= 1'b0;
      wait_clk(6);
      chk(32'(reg_out[3]), 32'h0000_0001);
   endtask : t_devclr
   // Synchronous clear then load on the free-running clock
   task automatic t_sync();
      wr_ok(OFS_CTRL, 32'h0000_0114);
      wait_clk(3);
      chk(32'(reg_out), 32'h0000_0000);
      wr_ok(OFS_CTRL, 32'h0000_0214);
      wait_clk(3);
      chk(32'(reg_out), 32'h0000_0008);
   endtask : t_sync
   // Verdict and end of run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   // Main sequence
   initial
   begin
      wait_clk(8);
      i_rst_n <= 1'b1;
      wait_clk(2);
      t_regs();
      t_arith();
      t_wide();
      t_reg();
      t_devclr();
      t_sync();
      end_of_test();
   end
   // Watchdog cuts a hang short
   initial
   begin
      #200us;
      miscompares++;
      end_of_test();
   end
endmodule : tb_top
